// [design/ccr_pkg.sv]
// Constants, encodings and state types for the card contact routing controller.
// Assumes a single 20 MHz system clock; all pin inputs are asynchronous to it.
package ccr_pkg;

  localparam int SYS_CLK_HZ = 20_000_000;
  // Rate of the input clock pin that the address and link timings are quoted in
  localparam int IN_CLK_HZ  = 20_000_000;

  // Address latch and bus-ready delays, in input-clock periods, then in cycles
  localparam int T_ADDR_LATCH_PERIODS = 22;
  localparam int T_BUS_READY_PERIODS  = 40;
  localparam logic [5:0] ADDR_LATCH_CYCLES =
    6'((T_ADDR_LATCH_PERIODS * (SYS_CLK_HZ / IN_CLK_HZ)));
  localparam logic [5:0] BUS_READY_CYCLES  =
    6'((T_BUS_READY_PERIODS * (SYS_CLK_HZ / IN_CLK_HZ)));

  // Settling time after a link master releases, before arbitration resumes
  localparam int T_LINK_HOLD_PERIODS = 2;
  localparam logic [1:0] LINK_HOLD_CYCLES =
    2'((T_LINK_HOLD_PERIODS * (SYS_CLK_HZ / IN_CLK_HZ)));

  // Converter clock derived from the system clock by a divider
  localparam int CONV_CLK_HZ = 4_000_000;
  localparam logic [2:0] CONV_HALF_CYCLES = 3'((SYS_CLK_HZ / (2 * CONV_CLK_HZ)));

  // Serial address: fixed prefix, then two pin bits, then a fixed one bit, then read/write bit
  localparam logic [3:0] ADDR_PREFIX   = 4'h4;
  localparam logic [7:0] GC_ADDR       = 8'h00;
  localparam logic [7:0] GC_RESET_BYTE = 8'h06;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Card clock source codes
  localparam logic [2:0] CKS_INPUT = 3'h0;
  localparam logic [2:0] CKS_CONV  = 3'h1;
  localparam logic [2:0] CKS_SOFT  = 3'h2;
  localparam logic [2:0] CKS_PASS  = 3'h3;

  localparam int NUM_SLOTS  = 5;
  localparam int NUM_LINKS  = 6;
  localparam int NUM_HOST   = 4;
  localparam int NUM_ASYNC  = 17;
  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 4;

  typedef enum logic [8:0] {
    TW_IDLE     = 9'b000000001,
    TW_ADDR     = 9'b000000010,
    TW_ACK_ADDR = 9'b000000100,
    TW_CMD      = 9'b000001000,
    TW_ACK_CMD  = 9'b000010000,
    TW_WDATA    = 9'b000100000,
    TW_ACK_DATA = 9'b001000000,
    TW_RDATA    = 9'b010000000,
    TW_RACK     = 9'b100000000
  } ccr_tw_e;

  typedef enum logic [3:0] {
    LK_IDLE = 4'b0001,
    LK_HOST = 4'b0010,
    LK_CARD = 4'b0100,
    LK_HOLD = 4'b1000
  } ccr_link_e;

endpackage

// [design/ccr_card_contact_routing_ctrl.sv]
// Card contact routing controller: serial slave front end, address latch,
// card clock/reset selection and transparent host-to-card I/O link arbitration.
// Assumes all pins are asynchronous to sys_clk; configuration bits are static
// ports from neighbouring logic on sys_clk.
`timescale 1ns/1ps

module ccr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + (AW+1)'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + (AW+1)'(1);
      end
    end
  end
endmodule // ccr_fifo

module ccr_card_contact_routing_ctrl
  import ccr_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // Serial bus pins (open drain)
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // Reset, address/transparent and misc pins
  input  wire logic        reset_pin_in,
  input  wire logic        addr_hi_or_clock_pin,
  input  wire logic        addr_lo_or_reset_pin,
  input  wire logic        input_clock_pin,
  input  wire logic        low_power_pin,
  input  wire logic        soft_reset_req,
  // Host lines: one, two, aux one, aux two
  input  wire logic [3:0]  host_line_in,
  output logic [3:0]       host_line_out,
  output logic [3:0]       host_line_oe,
  // Card link pins: slot1 io, slot1 c4, slot1 c8, shared io/c4, slot4 io, slot5 io
  input  wire logic [5:0]  card_io_line_in,
  output logic [5:0]       card_io_line_out,
  output logic [5:0]       card_io_line_oe,
  // Card clocks and resets (slot three reset pin is shared with slot two C8)
  output logic [4:0]       card_clock_out,
  output logic [4:0]       card_reset_out,
  // Converter and power control
  input  wire logic        first_converter_off,
  input  wire logic        second_converter_off,
  output logic             conv_a_stop,
  output logic             conv_b_stop,
  output logic             regulator_stop,
  output logic             reference_stop,
  output logic             converter_clock,
  // Slot configuration
  input  wire logic        slot_two_full_select,
  input  wire logic [14:0] card_clock_select,
  input  wire logic [4:0]  card_clock_halt,
  input  wire logic [4:0]  soft_card_clock_bit,
  input  wire logic [4:0]  soft_card_reset_bit,
  input  wire logic [4:0]  auto_reset_transition_en,
  input  wire logic [4:0]  auto_reset_level,
  input  wire logic [1:0]  reset_pass_en,
  input  wire logic        slot_one_link_disable,
  input  wire logic [4:0]  slot_link_disable,
  input  wire logic [3:0]  host_line_route_field,
  input  wire logic        soft_io_bit_slot_one,
  input  wire logic        soft_c4_bit_slot_one,
  input  wire logic        soft_c8_bit_slot_one,
  input  wire logic        soft_c4_bit_slot_two,
  input  wire logic        soft_c8_bit_slot_two,
  input  wire logic [2:0]  soft_card_io_bit,
  // Slew control
  input  wire logic [9:0]  slot_voltage_select,
  input  wire logic [9:0]  slew_force_en,
  input  wire logic [19:0] slew_force_value,
  output logic [19:0]      slew_ctrl,
  // Status
  output logic [1:0]       addr_latched,
  output logic             bus_ready,
  // Written command/data words
  output logic             wr_valid,
  input  wire logic        wr_ready,
  output logic [7:0]       wr_cmd,
  output logic [7:0]       wr_data,
  // Read data supply
  input  wire logic [7:0]  rd_byte,
  output logic             rd_taken
);

  function automatic logic [1:0] slew_auto(input logic [1:0] vsel);
    slew_auto = vsel;
  endfunction

  // Two-stage synchronisers for every pin input
  logic [NUM_ASYNC-1:0] async_in;
  logic [NUM_ASYNC-1:0] sync_a;
  logic [NUM_ASYNC-1:0] sync_b;

  assign async_in = {card_io_line_in, host_line_in, low_power_pin, input_clock_pin,
                     addr_lo_or_reset_pin, addr_hi_or_clock_pin, reset_pin_in,
                     sda_in, scl_in};

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sync_a <= '1;
      sync_b <= '1;
    end else begin
      sync_a <= async_in;
      sync_b <= sync_a;
    end
  end

  logic       scl_s;
  logic       sda_s;
  logic       rstpin_s;
  logic       a_hi_s;
  logic       a_lo_s;
  logic       inclk_s;
  logic       lowp_s;
  logic [3:0] host_s;
  logic [5:0] card_s;

  assign scl_s    = sync_b[0];
  assign sda_s    = sync_b[1];
  assign rstpin_s = sync_b[2];
  assign a_hi_s   = sync_b[3];
  assign a_lo_s   = sync_b[4];
  assign inclk_s  = sync_b[5];
  assign lowp_s   = sync_b[6];
  assign host_s   = sync_b[10:7];
  assign card_s   = sync_b[16:11];

  // Address latch and bus-ready timer
  logic       rstpin_q;
  logic       gc_reset;
  logic       latch_run;
  logic [5:0] latch_cnt;
  logic       latch_trig;

  assign latch_trig = (rstpin_s & ~rstpin_q) | soft_reset_req | gc_reset;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rstpin_q     <= 1'b1;
      latch_run    <= 1'b1;
      latch_cnt    <= '0;
      addr_latched <= '0;
      bus_ready    <= 1'b0;
    end else begin
      rstpin_q <= rstpin_s;
      if (!rstpin_s) begin
        latch_run <= 1'b0;
        latch_cnt <= '0;
        bus_ready <= 1'b0;
      end else if (latch_trig) begin
        latch_run <= 1'b1;
        latch_cnt <= '0;
        bus_ready <= 1'b0;
      end else if (latch_run) begin
        latch_cnt <= latch_cnt + 6'h01;
        if (latch_cnt == ADDR_LATCH_CYCLES - 6'h01) begin
          addr_latched <= {a_hi_s, a_lo_s};
        end
        if (latch_cnt == BUS_READY_CYCLES - 6'h01) begin
          bus_ready <= 1'b1;
          latch_run <= 1'b0;
        end
      end
    end
  end

  // Serial slave
  ccr_tw_e    tw_state;
  logic       scl_q;
  logic       sda_q;
  logic [7:0] shreg;
  logic [3:0] bitcnt;
  logic       sda_drive;
  logic       rw_read;
  logic       is_gc;
  logic       fifo_push;
  logic       fifo_in_ready;
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic       addr_match;
  logic [7:0] last_cmd;

  assign scl_rise   = scl_s & ~scl_q;
  assign scl_fall   = ~scl_s & scl_q;
  assign bus_start  = scl_s & scl_q & sda_q & ~sda_s;
  assign bus_stop   = scl_s & scl_q & ~sda_q & sda_s;
  // The bit after the two pin bits is always one; bit zero is read/write
  assign addr_match = shreg[7:1] == {ADDR_PREFIX, addr_latched, 1'b1};
  assign sda_out    = 1'b0;
  assign sda_oe     = sda_drive;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
      tw_state  <= TW_IDLE;
      shreg     <= '0;
      bitcnt    <= '0;
      sda_drive <= 1'b0;
      rw_read   <= 1'b0;
      is_gc     <= 1'b0;
      last_cmd  <= '0;
      fifo_push <= 1'b0;
      gc_reset  <= 1'b0;
      rd_taken  <= 1'b0;
    end else begin
      scl_q     <= scl_s;
      sda_q     <= sda_s;
      fifo_push <= 1'b0;
      gc_reset  <= 1'b0;
      rd_taken  <= 1'b0;
      if (bus_start && bus_ready) begin
        tw_state  <= TW_ADDR;
        bitcnt    <= '0;
        sda_drive <= 1'b0;
      end else if (bus_stop || !bus_ready) begin
        tw_state  <= TW_IDLE;
        sda_drive <= 1'b0;
      end else begin
        unique case (tw_state)
          TW_IDLE: begin
          end
          TW_ADDR, TW_CMD, TW_WDATA: begin
            if (scl_rise) begin
              shreg  <= {shreg[6:0], sda_s};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == BITS_PER_BYTE) begin
              bitcnt <= '0;
              if (tw_state == TW_ADDR) begin
                if (addr_match || shreg == GC_ADDR) begin
                  sda_drive <= 1'b1;
                  rw_read   <= shreg[0] & addr_match;
                  is_gc     <= ~addr_match;
                  tw_state  <= TW_ACK_ADDR;
                end else begin
                  tw_state <= TW_IDLE;
                end
              end else if (tw_state == TW_CMD) begin
                sda_drive <= 1'b1;
                last_cmd  <= shreg;
                gc_reset  <= is_gc && shreg == GC_RESET_BYTE;
                tw_state  <= TW_ACK_CMD;
              end else if (fifo_in_ready && !is_gc) begin
                sda_drive <= 1'b1;
                fifo_push <= 1'b1;
                tw_state  <= TW_ACK_DATA;
              end else begin
                tw_state <= TW_IDLE;
              end
            end
          end
          TW_ACK_ADDR, TW_ACK_CMD, TW_ACK_DATA: begin
            if (scl_fall) begin
              if (tw_state == TW_ACK_ADDR && rw_read) begin
                shreg     <= {rd_byte[6:0], 1'b0};
                sda_drive <= ~rd_byte[7];
                rd_taken  <= 1'b1;
                bitcnt    <= 4'h1;
                tw_state  <= TW_RDATA;
              end else begin
                sda_drive <= 1'b0;
                tw_state  <= (tw_state == TW_ACK_ADDR) ? TW_CMD : TW_WDATA;
              end
            end
          end
          TW_RDATA: begin
            if (scl_fall) begin
              if (bitcnt == BITS_PER_BYTE) begin
                sda_drive <= 1'b0;
                tw_state  <= TW_RACK;
              end else begin
                sda_drive <= ~shreg[7];
                shreg     <= {shreg[6:0], 1'b0};
                bitcnt    <= bitcnt + 4'h1;
              end
            end
          end
          TW_RACK: begin
            if (scl_rise && sda_s) begin
              tw_state <= TW_IDLE;
            end else if (scl_fall) begin
              shreg     <= {rd_byte[6:0], 1'b0};
              sda_drive <= ~rd_byte[7];
              rd_taken  <= 1'b1;
              bitcnt    <= 4'h1;
              tw_state  <= TW_RDATA;
            end
          end
        endcase
      end
    end
  end

  // Written words wait here; a full buffer refuses the next data byte
  logic [FIFO_WIDTH-1:0] fifo_out;

  ccr_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   ({last_cmd, shreg}),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (fifo_out)
  );

  // Command leaves with its own data byte, so a later command cannot re-tag it
  assign wr_cmd  = fifo_out[15:8];
  assign wr_data = fifo_out[7:0];

  // Power control
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      conv_a_stop    <= 1'b0;
      conv_b_stop    <= 1'b0;
      regulator_stop <= 1'b0;
      reference_stop <= 1'b0;
    end else begin
      conv_a_stop    <= first_converter_off;
      conv_b_stop    <= second_converter_off;
      regulator_stop <= first_converter_off & second_converter_off;
      reference_stop <= lowp_s;
    end
  end

  // Converter clock divider
  logic [2:0] conv_cnt;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      conv_cnt        <= '0;
      converter_clock <= 1'b0;
    end else if (conv_cnt == CONV_HALF_CYCLES - 3'h1) begin
      conv_cnt        <= '0;
      converter_clock <= ~converter_clock;
    end else begin
      conv_cnt <= conv_cnt + 3'h1;
    end
  end

  // Card clocks, resets and slew
  genvar gs;
  generate
    for (gs = 0; gs < NUM_SLOTS; gs++) begin : g_slot
      logic [2:0] sel;
      logic       src;
      logic       rst_src;
      assign sel = card_clock_select[3*gs +: 3];

      always_comb begin
        unique case (sel)
          CKS_INPUT: src = inclk_s;
          CKS_CONV:  src = converter_clock;
          CKS_SOFT:  src = soft_card_clock_bit[gs];
          CKS_PASS:  src = a_hi_s;
          default:   src = 1'b0;
        endcase
        if (auto_reset_transition_en[gs]) begin
          rst_src = auto_reset_level[gs];
        end else begin
          rst_src = soft_card_reset_bit[gs];
        end
        if (gs < 2 && reset_pass_en[gs % 2] && !auto_reset_transition_en[gs]) begin
          rst_src = a_lo_s;
        end
        if (gs == 2 && slot_two_full_select) begin
          rst_src = soft_c8_bit_slot_two;
        end
      end

      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          card_clock_out[gs] <= 1'b0;
          card_reset_out[gs] <= 1'b0;
          slew_ctrl[2*gs +: 2]       <= '0;
          slew_ctrl[2*gs + 10 +: 2]  <= '0;
        end else begin
          card_clock_out[gs] <= src & ~card_clock_halt[gs] &
                                ~(gs == 2 && slot_two_full_select);
          card_reset_out[gs] <= rst_src;
          slew_ctrl[2*gs +: 2] <= slew_force_en[gs] ? slew_force_value[2*gs +: 2]
                                  : slew_auto(slot_voltage_select[2*gs +: 2]);
          slew_ctrl[2*gs + 10 +: 2] <= slew_force_en[gs+5] ?
                                  slew_force_value[2*gs + 10 +: 2]
                                  : slew_auto(slot_voltage_select[2*gs +: 2]);
        end
      end
    end
  endgenerate

  // Transparent links
  logic [5:0] link_dis;
  logic [5:0] link_soft;
  logic [1:0] host_sel [NUM_LINKS];
  logic [3:0] host_pull [NUM_LINKS];

  assign link_dis  = {slot_link_disable[4], slot_link_disable[3],
                      slot_two_full_select ? slot_link_disable[1] : slot_link_disable[2],
                      {3{slot_one_link_disable}}};
  assign link_soft = {soft_card_io_bit[2], soft_card_io_bit[1],
                      slot_two_full_select ? soft_c4_bit_slot_two : soft_card_io_bit[0],
                      soft_c8_bit_slot_one, soft_c4_bit_slot_one, soft_io_bit_slot_one};
  assign host_sel[0] = host_line_route_field[1:0];
  assign host_sel[1] = 2'h2;
  assign host_sel[2] = 2'h3;
  assign host_sel[3] = host_line_route_field[3:2];
  assign host_sel[4] = host_line_route_field[3:2];
  assign host_sel[5] = host_line_route_field[3:2];

  genvar gl;
  generate
    for (gl = 0; gl < NUM_LINKS; gl++) begin : g_link
      ccr_link_e  st;
      logic [1:0] hold;
      logic       hin;
      logic       cin;
      assign hin = host_s[host_sel[gl]];
      assign cin = card_s[gl];

      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          st   <= LK_IDLE;
          hold <= '0;
        end else if (link_dis[gl]) begin
          st   <= LK_IDLE;
          hold <= '0;
        end else begin
          unique case (st)
            LK_IDLE: begin
              if (!cin) begin
                st <= LK_CARD;
              end else if (!hin) begin
                st <= LK_HOST;
              end
            end
            LK_HOST: begin
              if (hin) begin
                st   <= LK_HOLD;
                hold <= LINK_HOLD_CYCLES;
              end
            end
            LK_CARD: begin
              if (cin) begin
                st   <= LK_HOLD;
                hold <= LINK_HOLD_CYCLES;
              end
            end
            LK_HOLD: begin
              // Our own release takes the synchroniser depth to show; ignore it
              if (hold == 2'h0) begin
                st <= LK_IDLE;
              end else begin
                hold <= hold - 2'h1;
              end
            end
          endcase
        end
      end

      // Pulls low only; release lets the line return high
      assign card_io_line_out[gl] = 1'b0;
      assign card_io_line_oe[gl]  = link_dis[gl] ? ~link_soft[gl]
                                    : (st == LK_HOST);
      assign host_pull[gl] = (!link_dis[gl] && st == LK_CARD) ?
                             (4'h1 << host_sel[gl]) : 4'h0;
    end
  endgenerate

  always_comb begin
    host_line_oe = 4'h0;
    for (int l = 0; l < NUM_LINKS; l++) begin
      host_line_oe = host_line_oe | host_pull[l];
    end
  end

  assign host_line_out = 4'h0;

endmodule // ccr_card_contact_routing_ctrl

// [design/ccr_dummy_guard.sv]
`timescale 1ns/1ps
// Not used.

// [verif/ccr_chk.sv]
// Port checker for the routing controller.
// Assumes a bind into the top module; one clock domain.
`timescale 1ns/1ps
module ccr_chk (
  input wire logic       sys_clk, sys_rst, first_converter_off, second_converter_off,
  input wire logic       low_power_pin, slot_one_link_disable, conv_a_stop,
  input wire logic       regulator_stop, reference_stop, converter_clock, bus_ready,
  input wire logic [4:0] auto_reset_transition_en, soft_card_reset_bit, card_clock_halt,
  input wire logic [4:0] card_reset_out, card_clock_out,
  input wire logic [3:0] host_line_route_field, host_line_in, host_line_oe,
  input wire logic [5:0] card_io_line_in
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic [6:0] cyc;
  // Saturates so long runs never wrap back into the start-up window
  always_ff @(posedge sys_clk) cyc <= sys_rst ? 7'h00 : cyc + {6'h00, cyc != 7'h7f};
  sequence grab;
    host_line_route_field[1:0] == 2'h0 && !slot_one_link_disable && host_line_in[0] &&
    $fell(card_io_line_in[0]);
  endsequence
  chk_conv_a_stop: assert property (
    $stable(first_converter_off)[*4] |-> conv_a_stop == first_converter_off)
    else $error("converter a stop wrong");
  chk_regulator_both: assert property (
    $stable({first_converter_off, second_converter_off})[*4] |->
    regulator_stop == (first_converter_off && second_converter_off)) else $error("regulator");
  chk_ref_stop: assert property (
    $stable(low_power_pin)[*4] |-> reference_stop == low_power_pin) else $error("reference");
  chk_soft_reset: assert property (
    ($stable(soft_card_reset_bit[3]) && !auto_reset_transition_en[3])[*4] |->
    card_reset_out[3] == soft_card_reset_bit[3]) else $error("slot four reset");
  chk_clock_halt: assert property (
    card_clock_halt[0][*4] |-> $stable(card_clock_out[0])) else $error("halted clock moved");
  chk_conv_rate: assert property (
    $rose(converter_clock) |=> converter_clock ##1 !converter_clock[*2] ##1 converter_clock)
    else $error("converter clock rate");
  chk_ready_wait: assert property (
    cyc < 7'h26 |-> !bus_ready) else $error("bus ready too early");
  chk_link_pull: assert property (
    grab |-> ##[1:4] host_line_oe[0]) else $error("host side not pulled");
endmodule // ccr_chk

// [verif/ccr_far_model.sv]
// Far side: serial host master and pulled-up host and card wires.
// Assumes the bench asks for pull-downs on host_pull and card_pull.
`timescale 1ns/1ps
module ccr_far_model (
  input  wire logic       sys_clk, sda_oe,
  input  wire logic [3:0] host_line_oe, host_pull,
  input  wire logic [5:0] card_io_line_oe, card_pull,
  output logic            scl_in, sda_in,
  output logic [3:0]      host_line_in,
  output logic [5:0]      card_io_line_in
);
  logic sda_drv = 1'b1;
  initial scl_in = 1'b1;
  // Released lines float to the pull-up level
  assign sda_in          = sda_drv & ~sda_oe;
  assign host_line_in    = ~(host_pull | host_line_oe);
  assign card_io_line_in = ~(card_pull | card_io_line_oe);
  // One address byte MSB first, ack slot, then STOP; SCL rests high
  // SDA only moves while SCL is low, so no bit is mistaken for START or STOP
  task automatic xfer(input logic [7:0] b, output logic ack);
    sda_drv <= 1'b0;
    for (int i = 35; i >= 0; i--) begin
      repeat (4) @(posedge sys_clk);
      if (i[0])
        scl_in <= ~i[1];
      else if (i[1])
        sda_drv <= (i > 3) ? b[i/4-1] : 1'b1;
      else
        ack = ~sda_in;
    end
    repeat (4) @(posedge sys_clk);
    scl_in <= 1'b0;
    repeat (4) @(posedge sys_clk);
    sda_drv <= 1'b0;
    repeat (4) @(posedge sys_clk);
    scl_in <= 1'b1;
    repeat (4) @(posedge sys_clk);
    sda_drv <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask
endmodule // ccr_far_model

// [verif/tb_ccr_card_contact_routing_ctrl.sv]
// Bench: address latch and match, clocks, power stops, resets, link arbitration.
// Assumes the far-side model resolves every open-drain line.
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end
module tb_ccr_card_contact_routing_ctrl;
  import ccr_pkg::*;
  int num_errors = 0, compares = 0;
  logic ack, sys_clk = 0, sys_rst = 1, reset_pin_in = 1, addr_hi_or_clock_pin = 1;
  logic addr_lo_or_reset_pin = 0, input_clock_pin = 0, low_power_pin = 0, soft_reset_req = 0;
  logic first_converter_off = 0, second_converter_off = 0, slot_two_full_select = 0;
  logic slot_one_link_disable = 1, soft_io_bit_slot_one = 1, soft_c4_bit_slot_one = 1;
  logic soft_c8_bit_slot_one = 1, soft_c4_bit_slot_two = 1, soft_c8_bit_slot_two = 1;
  logic wr_ready = 1, sda_out, sda_oe, scl_in, sda_in, conv_a_stop, conv_b_stop;
  logic regulator_stop, reference_stop, converter_clock, bus_ready, wr_valid, rd_taken;
  logic [1:0] reset_pass_en = '0, addr_latched;
  logic [2:0] soft_card_io_bit = '1;
  logic [3:0] host_line_route_field = '0, host_line_in, host_line_out, host_line_oe;
  logic [3:0] host_pull = '0;
  logic [4:0] card_clock_halt = '0, soft_card_clock_bit = '0, soft_card_reset_bit = '0;
  logic [4:0] auto_reset_transition_en = '0, auto_reset_level = '0, slot_link_disable = '1;
  logic [4:0] card_clock_out, card_reset_out;
  logic [5:0] card_io_line_in, card_io_line_out, card_io_line_oe, card_pull = '0;
  // All-ones read data leaves SDA released, so the model's STOP still ends a read
  logic [7:0] rd_byte = '1, wr_cmd, wr_data;
  logic [9:0] slot_voltage_select = '0, slew_force_en = '0;
  logic [14:0] card_clock_select = '0;
  logic [19:0] slew_force_value = '0, slew_ctrl;
  always #25 sys_clk = ~sys_clk;
  ccr_card_contact_routing_ctrl u_dut (.*);
  ccr_far_model u_far (.*);
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic close_out();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic t_addr();
    `CHK(addr_latched, 2'h2)
    u_far.xfer(8'h42, ack);
    `CHK(ack, 1'b0)
    u_far.xfer(8'h4b, ack);
    `CHK(ack, 1'b1)
    addr_hi_or_clock_pin <= 1'b0;
    addr_lo_or_reset_pin <= 1'b1;
    reset_pin_in <= 1'b0;
    cyc(4);
    reset_pin_in <= 1'b1;
    cyc(70); // serial slave not ready for 40 periods
    `CHK(addr_latched, 2'h1)
    u_far.xfer(8'h46, ack);
    `CHK(ack, 1'b1)
    $display("addr done");
  endtask
  task automatic t_clocks();
    card_clock_select[5:0] <= {CKS_SOFT, CKS_PASS};
    soft_card_clock_bit[1] <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      addr_hi_or_clock_pin <= i[0]; // link clock, 400 ns period
      cyc(4);
      `CHK(card_clock_out[0], i[0])
    end
    `CHK(card_clock_out[1], 1'b1)
    card_clock_halt[0] <= 1'b1;
    cyc(12);
    `CHK(card_clock_out[0], 1'b0)
    $display("clocks done");
  endtask
  task automatic t_power();
    first_converter_off <= 1'b1;
    cyc(5);
    `CHK({conv_a_stop, regulator_stop}, 2'h2)
    second_converter_off <= 1'b1;
    cyc(5);
    `CHK({conv_b_stop, regulator_stop}, 2'h3)
    low_power_pin <= 1'b1; // both shutdown bits are already set
    soft_card_reset_bit[3] <= 1'b1;
    soft_card_reset_bit[0] <= 1'b1;
    reset_pass_en[0] <= 1'b1;
    addr_lo_or_reset_pin <= 1'b0;
    slot_voltage_select[1:0] <= 2'h3;
    slew_force_en[5] <= 1'b1;
    slew_force_value[11:10] <= 2'h1;
    cyc(5);
    `CHK({slew_ctrl[11:10], slew_ctrl[1:0]}, 4'h7)
    `CHK(reference_stop, 1'b1)
    `CHK(card_reset_out[3], 1'b1)
    `CHK(card_reset_out[0], 1'b0)
    $display("power done");
  endtask
  task automatic t_link();
    slot_one_link_disable <= 1'b0;
    cyc(8);
    `CHK(host_line_in[0], 1'b1)
    card_pull[0] <= 1'b1;
    cyc(5);
    `CHK(host_line_in[0], 1'b0)
    card_pull[0] <= 1'b0;
    cyc(12);
    {host_pull[0], card_pull[0]} <= 2'h3;
    cyc(6);
    `CHK({host_line_oe[0], card_io_line_oe[0]}, 2'h2)
    {host_pull[0], card_pull[0]} <= 2'h0;
    cyc(12);
    slot_one_link_disable <= 1'b1;
    soft_io_bit_slot_one <= 1'b0;
    cyc(4);
    `CHK({host_line_oe[0], card_io_line_oe[0]}, 2'h1)
    $display("link done");
  endtask
  initial begin
    cyc(16);
    sys_rst <= 1'b0;
    cyc(60);
    t_addr();
    t_clocks();
    t_power();
    t_link();
    close_out();
  end
  initial begin
    cyc(20000);
    num_errors++;
    close_out();
  end
endmodule // tb_ccr_card_contact_routing_ctrl
bind ccr_card_contact_routing_ctrl ccr_chk u_chk (.*);
